// ### core/excitation_bias_regs.svh
/*
 Register offsets, field positions, reset values and decode codes for the
 excitation current and sensor bias configuration bank.
 Assumes a 32-bit APB slave where each register takes one aligned word.
*/
`ifndef EXCITATION_BIAS_REGS_SVH
`define EXCITATION_BIAS_REGS_SVH

// Register indices as printed, byte address is four times the index
`define MAG_CTRL_INDEX        8'h06
`define ROUTE_SELECT_INDEX    8'h07
`define BIAS_SELECT_INDEX     8'h08
`define MAG_CTRL_ADDR         12'h018
`define ROUTE_SELECT_ADDR     12'h01C
`define BIAS_SELECT_ADDR      12'h020

// Reset values
`define MAG_CTRL_RESET        8'h00
`define ROUTE_SELECT_RESET    8'hFF
`define BIAS_SELECT_RESET     8'h00

// Magnitude register fields
`define MAG_RAIL_MON_BIT      7
`define MAG_SWITCH_BIT        6
`define MAG_RSVD_MSB          5
`define MAG_RSVD_LSB          4
`define MAG_FIELD_MSB         3
`define MAG_FIELD_LSB         0

// Routing register fields
`define ROUTE_TWO_MSB         7
`define ROUTE_TWO_LSB         4
`define ROUTE_ONE_MSB         3
`define ROUTE_ONE_LSB         0

// Bias register fields
`define BIAS_LEVEL_BIT        7
`define BIAS_COMMON_BIT       6
`define BIAS_PINS_MSB         5
`define BIAS_PINS_LSB         0

// Magnitude codes and currents in microamps
`define MAG_CODE_OFF          4'h0
`define MAG_CODE_10UA         4'h1
`define MAG_CODE_100UA        4'h3
`define MAG_CODE_250UA        4'h4
`define MAG_CODE_500UA        4'h5
`define MAG_CODE_750UA        4'h6
`define MAG_CODE_1000UA       4'h7
`define MAG_CODE_1500UA       4'h8
`define MAG_CODE_2000UA       4'h9
`define CUR_OFF_UA            11'h000
`define CUR_10UA              11'h00A
`define CUR_100UA             11'h064
`define CUR_250UA             11'h0FA
`define CUR_500UA             11'h1F4
`define CUR_750UA             11'h2EE
`define CUR_1000UA            11'h3E8
`define CUR_1500UA            11'h5DC
`define CUR_2000UA            11'h7D0

// Routing codes
`define ROUTE_LAST_LOW_AIN    4'h5
`define ROUTE_AIN6_OR_REFP    4'h6
`define ROUTE_AIN7_OR_REFN    4'h7
`define ROUTE_LAST_WIDE_AIN   4'hB
`define ROUTE_COMMON          4'hC

`endif

// ### core/excitation_bias_pkg.sv
/*
 Types shared by the excitation and bias configuration bank.
 Assumes the constants header supplies all numeric values.
*/
package excitation_bias_pkg;

    // Pin set one excitation source may be routed to
    typedef struct packed {
        logic        common_analog_input;
        logic        second_ref_negative;
        logic        second_ref_positive;
        logic [11:0] analog_input;
    } route_pins_s;

    // Excitation source controls
    typedef struct packed {
        logic        rail_monitor_enable;
        logic        low_side_switch_close;
        logic [10:0] excitation_current_ua;
        logic        sources_on;
        route_pins_s excitation_source_one;
        route_pins_s excitation_source_two;
    } excitation_s;

    // Sensor bias controls
    typedef struct packed {
        logic       bias_level_select;
        logic       bias_on_common_input;
        logic [5:0] bias_on_input;
        logic       bias_generator_enable;
    } sensor_bias_s;

endpackage

// ### core/excitation_route_decode.sv
/*
 Decodes one four-bit routing nibble into a one-hot pin selection.
 Assumes a purely combinational use; the caller registers the nibble.
*/
`timescale 1ns/10ps
`default_nettype none
`include "excitation_bias_regs.svh"

module excitation_route_decode
    import excitation_bias_pkg::*;
(
    input  wire logic [3:0] route_code,    // Stored routing nibble
    input  wire logic       twelve_inputs, // Wide variant when high
    output route_pins_s     pins           // One-hot pin selection
);

    // Nibble to pin, six-input variant swaps 6/7 for second reference
    always_comb begin
        pins = '0;
        if (route_code <= `ROUTE_LAST_LOW_AIN) begin
            pins.analog_input[route_code] = 1'b1;
        end else if (route_code == `ROUTE_AIN6_OR_REFP) begin
            if (twelve_inputs) begin
                pins.analog_input[6] = 1'b1;
            end else begin
                pins.second_ref_positive = 1'b1;
            end
        end else if (route_code == `ROUTE_AIN7_OR_REFN) begin
            if (twelve_inputs) begin
                pins.analog_input[7] = 1'b1;
            end else begin
                pins.second_ref_negative = 1'b1;
            end
        end else if (route_code <= `ROUTE_LAST_WIDE_AIN) begin
            // Only the wide variant has inputs 8 to 11
            if (twelve_inputs) begin
                pins.analog_input[route_code] = 1'b1;
            end
        end else if (route_code == `ROUTE_COMMON) begin
            pins.common_analog_input = 1'b1;
        end
        // Codes above common leave the source disconnected
    end

endmodule // excitation_route_decode
`default_nettype wire

// ### core/excitation_bias_config_regs.sv
/*
 APB register bank for excitation current sources, low-side switch,
 rail monitor and sensor bias configuration, with decoded outputs.
 Registers (byte address, reset value):
   0x18 magnitude control, 00h
   0x1C route select, FFh
   0x20 sensor bias select, 00h
 Assumes a single clock domain, APB master on pclk, and a power-down
 level produced by logic on the same clock.
*/
// Chosen here: register access over APB.
// Behaviour
// - Magnitude bit 7 enables rail monitor
// - Magnitude bit 6 closes low-side switch
// - Power-down forces the low-side switch open
// - One magnitude field drives both sources
// - Codes 0,1,3,4: off,10,100,250 uA
// - Codes 5 to 9: 500 to 2000 uA
// - Codes 1010 to 1111 turn sources off
// - Upper route nibble picks source two pin
// - Lower route nibble picks source one pin
// - Codes 6,7: inputs or second reference
// - Codes 8 to 11: inputs, wide variant
// - Code 12 common, above disconnected, reset Fh
// - Bias register: level, common, six pin enables
// - Level bit: half or twelfth of rails
// - Each pin bias bit connects its pin
// - Bias generator off when no pin enabled

`timescale 1ns/10ps
`default_nettype none
`include "excitation_bias_regs.svh"

module excitation_bias_config_regs
    import excitation_bias_pkg::*;
#(
    parameter bit TWELVE_INPUTS = 1'b1  // Wide variant when set
) (
    input  wire logic        pclk,       // Register clock, 40 MHz
    input  wire logic        presetn,    // Asynchronous reset, low

    // APB slave port
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB access phase
    input  wire logic        pwrite,     // APB direction, high writes
    input  wire logic [11:0] paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    input  wire logic [3:0]  pstrb,      // APB write byte strobes
    output logic             pready,     // APB ready, never waits
    output logic [31:0]      prdata,     // APB read data, registered
    output logic             pslverr,    // APB error, unmapped address

    // Device side
    input  wire logic        power_down, // Device power-down level
    output excitation_s      excitation, // Excitation controls
    output sensor_bias_s     sensor_bias // Sensor bias controls
);

    // Stored register contents
    logic [7:0]  excitation_magnitude_ctrl_q; // Magnitude register
    logic [7:0]  excitation_route_select_q;   // Routing register
    logic [7:0]  sensor_bias_select_q;        // Bias register

    // Read path
    logic [31:0] prdata_q;                    // Captured read data
    logic [7:0]  read_byte_d;                 // Selected read byte

    // Bus phase decode
    logic        setup_phase;     // First cycle of a transfer
    logic        access_phase;    // Completing cycle

    // Address hits
    logic        hit_magnitude;   // Address matches magnitude reg
    logic        hit_route;       // Address matches routing reg
    logic        hit_bias;        // Address matches bias reg
    logic        addr_mapped;     // Any register matched
    logic        write_lane0;     // Write with low byte strobe set

    // Decoded per-source pins
    route_pins_s source_pins [2]; // Index 0 source one, 1 two
    logic [3:0]  route_nibble [2];// Routing nibble per source

    // Decoded current and derived controls
    logic [10:0] current_ua_d;    // Common current in microamps
    logic        switch_close_d;  // Switch after power-down gate

    // Bias side
    logic [5:0]  bias_pins;       // Per-input bias enables
    logic        bias_any_pin;    // Any pin has bias connected

    // Stray codes give no current, so a
    // bad write cannot over-excite a sensor
    // Code 0010 is unlisted and stays off
    // Magnitude code to common current value
    function automatic logic [10:0] magnitude_to_ua(
        input logic [3:0] code
    );
        logic [10:0] ua;

        ua = `CUR_OFF_UA;

        case (code)
            `MAG_CODE_OFF:    ua = `CUR_OFF_UA;
            `MAG_CODE_10UA:   ua = `CUR_10UA;
            `MAG_CODE_100UA:  ua = `CUR_100UA;
            `MAG_CODE_250UA:  ua = `CUR_250UA;

            `MAG_CODE_500UA:  ua = `CUR_500UA;
            `MAG_CODE_750UA:  ua = `CUR_750UA;
            `MAG_CODE_1000UA: ua = `CUR_1000UA;
            `MAG_CODE_1500UA: ua = `CUR_1500UA;
            `MAG_CODE_2000UA: ua = `CUR_2000UA;

            // Upper codes and the unlisted code stay off
            default:          ua = `CUR_OFF_UA;
        endcase
        return ua;
    endfunction

    // Setup then one access cycle; writes
    // land at the access edge
    // Transfer phases
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;

    // Only byte zero of each word exists
    // Address decode against the word addresses
    assign hit_magnitude = (paddr == `MAG_CTRL_ADDR);
    assign hit_route     = (paddr == `ROUTE_SELECT_ADDR);
    assign hit_bias      = (paddr == `BIAS_SELECT_ADDR);
    assign addr_mapped   = hit_magnitude | hit_route | hit_bias;

    // No error for a clear strobe
    // Writes land only when the low byte lane is strobed
    assign write_lane0 = access_phase & pwrite & pstrb[0];

    // The bank never stalls the master
    // Zero wait states; errors only on unmapped access
    assign pready  = 1'b1;
    assign pslverr = access_phase & ~addr_mapped;
    assign prdata  = prdata_q;

    // Reserved pair forced to zero so a
    // careless write leaves no stale ones
    // Magnitude register, reserved bits never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            excitation_magnitude_ctrl_q <= `MAG_CTRL_RESET;
        end else if (write_lane0 && hit_magnitude) begin
            // Rail monitor, switch and magnitude take the write
            excitation_magnitude_ctrl_q[`MAG_RAIL_MON_BIT] <=
                pwdata[`MAG_RAIL_MON_BIT];
            excitation_magnitude_ctrl_q[`MAG_SWITCH_BIT] <=
                pwdata[`MAG_SWITCH_BIT];
            excitation_magnitude_ctrl_q[`MAG_FIELD_MSB:`MAG_FIELD_LSB] <=
                pwdata[`MAG_FIELD_MSB:`MAG_FIELD_LSB];

            // Reserved pair held at zero whatever is written
            excitation_magnitude_ctrl_q[`MAG_RSVD_MSB:`MAG_RSVD_LSB] <=
                2'h0;
        end
    end

    // Sources stay off the pins until set
    // Routing register, both nibbles start disconnected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            excitation_route_select_q <= `ROUTE_SELECT_RESET;
        end else if (write_lane0 && hit_route) begin
            // Whole byte is read/write
            excitation_route_select_q <= pwdata[7:0];
        end
    end

    // Nothing here clears by itself
    // Bias register, all eight bits read/write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sensor_bias_select_q <= `BIAS_SELECT_RESET;
        end else if (write_lane0 && hit_bias) begin
            // Level, common and pin enables stored as written
            sensor_bias_select_q <= pwdata[7:0];
        end
    end

    // Same decode as writes, so reads and
    // writes always agree on the register
    // Read byte multiplexer
    always_comb begin
        read_byte_d = 8'h00;
        if (hit_magnitude) begin
            // Reserved bits read back as zero
            read_byte_d = excitation_magnitude_ctrl_q;
            read_byte_d[`MAG_RSVD_MSB:`MAG_RSVD_LSB] = 2'h0;
        end else if (hit_route) begin
            read_byte_d = excitation_route_select_q;
        end else if (hit_bias) begin
            read_byte_d = sensor_bias_select_q;
        end

        // Unmapped addresses read zero
    end

    // Taken at setup so prdata is a flop
    // yet valid with zero wait states
    // Read data captured in setup, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            // Upper bits read as zero
            prdata_q <= {24'h00_0000, read_byte_d};
        end
    end

    // Low nibble is source one
    // Split the routing byte per source
    assign route_nibble[0] =
        excitation_route_select_q[`ROUTE_ONE_MSB:`ROUTE_ONE_LSB];

    assign route_nibble[1] =
        excitation_route_select_q[`ROUTE_TWO_MSB:`ROUTE_TWO_LSB];

    // The variant only changes codes 6-11
    // One decoder per excitation source
    for (genvar src = 0; src < 2; src++) begin : g_source
        // Same mapping for both nibbles
        excitation_route_decode u_decode (
            .route_code    (route_nibble[src]),
            .twelve_inputs (TWELVE_INPUTS),
            .pins          (source_pins[src])
        );
    end

    // Decoded from storage, not the bus
    // Common current for both sources
    assign current_ua_d = magnitude_to_ua(
        excitation_magnitude_ctrl_q[`MAG_FIELD_MSB:`MAG_FIELD_LSB]
    );

    // Gated on the output path, so the
    // stored bit reads back as written
    // Switch opens in power-down regardless of the stored bit
    assign switch_close_d =
        excitation_magnitude_ctrl_q[`MAG_SWITCH_BIT] &
        ~power_down;

    // Common input counts as a pin too
    // Bias pin enables and generator gate
    assign bias_pins = sensor_bias_select_q[`BIAS_PINS_MSB:`BIAS_PINS_LSB];
    assign bias_any_pin =
        (|bias_pins) |
        sensor_bias_select_q[`BIAS_COMMON_BIT];

    // One clock of latency keeps decode
    // glitches off the analog controls
    // Excitation outputs registered from stored fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            excitation <= '0;
            // Route nibbles at Fh decode to none
            excitation.excitation_source_one <= '0;
            excitation.excitation_source_two <= '0;
        end else begin
            // Rail monitor follows its bit directly
            excitation.rail_monitor_enable <=
                excitation_magnitude_ctrl_q[`MAG_RAIL_MON_BIT];

            // Switch drive with power-down override
            excitation.low_side_switch_close <= switch_close_d;

            // One value shared by both sources
            excitation.excitation_current_ua <= current_ua_d;
            excitation.sources_on <=
                (current_ua_d != `CUR_OFF_UA);

            // Pin selection per source
            excitation.excitation_source_one <= source_pins[0];
            excitation.excitation_source_two <= source_pins[1];
        end
    end

    // Same latency as the excitation side
    // Bias outputs registered from stored fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sensor_bias <= '0;
        end else begin
            // Low selects half, high a twelfth of the rail sum
            sensor_bias.bias_level_select <=
                sensor_bias_select_q[`BIAS_LEVEL_BIT];

            // Each enabled pin connects independently
            sensor_bias.bias_on_common_input <=
                sensor_bias_select_q[`BIAS_COMMON_BIT];
            sensor_bias.bias_on_input <= bias_pins;

            // Generator idle when nothing is connected
            sensor_bias.bias_generator_enable <= bias_any_pin;
        end
    end

endmodule // excitation_bias_config_regs
`default_nettype wire

// ### test/excitation_bias_config_regs_props.sv
/*
 Checker for the excitation and bias register bank, bound to its top.
 Assumes the top module's ports only, one clock, async active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "excitation_bias_regs.svh"

module excitation_bias_config_regs_props
    import excitation_bias_pkg::*;
#(
    parameter bit TWELVE_INPUTS = 1'b1  // Wide variant when set
) (
    input  wire logic         pclk,        // Register clock
    input  wire logic         presetn,     // Async reset, low
    input  wire logic         psel,        // APB select
    input  wire logic         penable,     // APB access phase
    input  wire logic         pwrite,      // APB direction
    input  wire logic [11:0]  paddr,       // APB byte address
    input  wire logic [31:0]  pwdata,      // APB write data
    input  wire logic [3:0]   pstrb,       // APB strobes
    input  wire logic         pready,      // APB ready
    input  wire logic [31:0]  prdata,      // APB read data
    input  wire logic         pslverr,     // APB error
    input  wire logic         power_down,  // Power-down level
    input  wire excitation_s  excitation,  // Excitation controls
    input  wire sensor_bias_s sensor_bias  // Sensor bias controls
);
    logic wr_any;   // Accepted write in access phase
    logic wr_mag;   // Write to magnitude register
    logic wr_route; // Write to routing register
    logic wr_bias;  // Write to bias register

    // Write decodes
    assign wr_any   = psel && penable && pwrite && pstrb[0];
    assign wr_mag   = wr_any && (paddr == `MAG_CTRL_ADDR);
    assign wr_route = wr_any && (paddr == `ROUTE_SELECT_ADDR);
    assign wr_bias  = wr_any && (paddr == `BIAS_SELECT_ADDR);

    // Expected current for a magnitude code
    function automatic logic [10:0] cur_of(input logic [3:0] c);
        case (c)
            `MAG_CODE_10UA:   return `CUR_10UA;
            `MAG_CODE_100UA:  return `CUR_100UA;
            `MAG_CODE_250UA:  return `CUR_250UA;
            `MAG_CODE_500UA:  return `CUR_500UA;
            `MAG_CODE_750UA:  return `CUR_750UA;
            `MAG_CODE_1000UA: return `CUR_1000UA;
            `MAG_CODE_1500UA: return `CUR_1500UA;
            `MAG_CODE_2000UA: return `CUR_2000UA;
            default:          return `CUR_OFF_UA;
        endcase
    endfunction

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rail_mon_a: assert property (wr_mag |-> ##2
        excitation.rail_monitor_enable == $past(pwdata[7], 2))
        else $error("rail monitor enable mismatch");
    switch_set_a: assert property (wr_mag ##1 !power_down |-> ##1
        excitation.low_side_switch_close == $past(pwdata[6], 2))
        else $error("low-side switch mismatch");
    pd_open_a: assert property (power_down |=>
        !excitation.low_side_switch_close)
        else $error("switch closed in power-down");
    rsvd_read_a: assert property (psel && penable && !pwrite &&
        paddr == `MAG_CTRL_ADDR |-> prdata[5:4] == 2'b00)
        else $error("reserved bits read nonzero");
    mag_cur_a: assert property (wr_mag |-> ##2
        excitation.excitation_current_ua == cur_of($past(pwdata[3:0], 2)))
        else $error("excitation current mismatch");
    on_flag_a: assert property (excitation.sources_on ==
        (excitation.excitation_current_ua != 11'h000))
        else $error("sources on flag mismatch");
    route_low_a: assert property (wr_route && pwdata[7:4] < 4'h6
        |-> ##2 excitation.excitation_source_two ==
        {3'b000, 12'h001 << $past(pwdata[7:4], 2)})
        else $error("source two pin mismatch");
    route_off_a: assert property (wr_route && pwdata[3:0] > 4'hC
        |-> ##2 excitation.excitation_source_one == '0)
        else $error("source one not disconnected");
    bias_copy_a: assert property (wr_bias |-> ##2
        {sensor_bias.bias_level_select, sensor_bias.bias_on_common_input,
        sensor_bias.bias_on_input} == $past(pwdata[7:0], 2))
        else $error("bias fields mismatch");
    bias_gen_a: assert property (sensor_bias.bias_generator_enable ==
        (sensor_bias.bias_on_common_input || |sensor_bias.bias_on_input))
        else $error("bias generator enable mismatch");

    // Main scenarios reached
    mag_wr_c: cover property (wr_mag);
    route_wr_c: cover property (wr_route);
    pd_c: cover property ((power_down && excitation.low_side_switch_close)
        ##1 !excitation.low_side_switch_close);
    err_c: cover property (psel && penable && pslverr);
endmodule // excitation_bias_config_regs_props

bind excitation_bias_config_regs excitation_bias_config_regs_props #(
    .TWELVE_INPUTS(TWELVE_INPUTS)
) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .power_down(power_down), .excitation(excitation),
    .sensor_bias(sensor_bias)
);
`default_nettype wire

// ### test/excitation_bias_config_regs_tb_top.sv
/*
 Self-checking bench for the excitation and bias register bank.
 Assumes zero-wait APB slave and outputs one edge after each write.
*/
`timescale 1ns/10ps
`default_nettype none
`include "excitation_bias_regs.svh"

module excitation_bias_config_regs_tb_top
    import excitation_bias_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, power_down;
    logic [11:0]  paddr;       // Byte address
    logic [31:0]  pwdata;      // Write data
    logic [3:0]   pstrb;       // Write strobes
    logic         pready, pslverr, rerr, err6;
    logic [31:0]  prdata, rdata, rd6;
    excitation_s  exc, exc6;   // Wide and six-input variants
    sensor_bias_s bias, bias6;
    logic [7:0]   v;           // Written byte
    logic [10:0]  cur_tab [16]; // Expected currents
    int           bad_count, compares;

    excitation_bias_config_regs uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .power_down(power_down), .excitation(exc),
        .sensor_bias(bias));
    excitation_bias_config_regs #(.TWELVE_INPUTS(1'b0)) uut_six (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(), .prdata(rd6), .pslverr(err6), .power_down(power_down),
        .excitation(exc6), .sensor_bias(bias6));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Counts then verdict
    task automatic finish_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One APB transfer; only the watchdog ends a wait
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'hF);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rdata, {24'h0, e});
        chk(rd6, {24'h0, e});
    endtask
    // Let decoded outputs land
    task automatic settle();
        @(posedge pclk);
        @(negedge pclk);
    endtask

    // Expected pin selection for a route code
    function automatic route_pins_s pins(input logic [3:0] c, input bit w);
        route_pins_s p = '0;
        if (c < 4'h6 || (w && c < 4'hC)) p.analog_input[c] = 1'b1;
        else if (c == 4'h6 && !w) p.second_ref_positive = 1'b1;
        else if (c == 4'h7 && !w) p.second_ref_negative = 1'b1;
        else if (c == `ROUTE_COMMON) p.common_analog_input = 1'b1;
        return p;
    endfunction

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        cur_tab = '{1: `CUR_10UA, 3: `CUR_100UA, 4: `CUR_250UA,
            5: `CUR_500UA, 6: `CUR_750UA, 7: `CUR_1000UA,
            8: `CUR_1500UA, 9: `CUR_2000UA, default: `CUR_OFF_UA};
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; power_down = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        rd(`MAG_CTRL_ADDR, `MAG_CTRL_RESET);
        rd(`ROUTE_SELECT_ADDR, `ROUTE_SELECT_RESET);
        rd(`BIAS_SELECT_ADDR, `BIAS_SELECT_RESET);
        chk(exc.excitation_source_one, 0);
        chk(exc.low_side_switch_close, 0);
        // Every magnitude code, reserved bits written as zero
        for (int i = 0; i < 16; i++) begin
            v = {i[0], i[1], 2'b00, i[3:0]};
            wr(`MAG_CTRL_ADDR, v);
            settle();
            chk(exc.excitation_current_ua, cur_tab[i]);
            chk(exc.sources_on, cur_tab[i] != 0);
            chk(exc.rail_monitor_enable, i[0]);
            chk(exc.low_side_switch_close, i[1]);
            rd(`MAG_CTRL_ADDR, {v[7:6], 2'b00, v[3:0]});
        end
        // Power-down overrides a closed switch
        wr(`MAG_CTRL_ADDR, 8'h40);
        @(posedge pclk);
        power_down <= 1'b1;
        settle();
        chk(exc.low_side_switch_close, 0);
        rd(`MAG_CTRL_ADDR, 8'h40);
        @(posedge pclk);
        power_down <= 1'b0;
        settle();
        chk(exc.low_side_switch_close, 1);
        // Every route code on both nibbles and both variants
        for (int i = 0; i < 16; i++) begin
            v = {i[3:0], ~i[3:0]};
            wr(`ROUTE_SELECT_ADDR, v);
            settle();
            chk(exc.excitation_source_two, pins(v[7:4], 1));
            chk(exc.excitation_source_one, pins(v[3:0], 1));
            chk(exc6.excitation_source_two, pins(v[7:4], 0));
            chk(exc6.excitation_source_one, pins(v[3:0], 0));
            rd(`ROUTE_SELECT_ADDR, v);
        end
        // Bias patterns including level alone
        foreach (cur_tab[i]) begin
            v = (i < 8) ? (8'h01 << i) : ((i < 12) ? 8'hC1 : 8'h7F);
            wr(`BIAS_SELECT_ADDR, v);
            settle();
            chk({bias.bias_level_select, bias.bias_on_common_input,
                bias.bias_on_input}, v);
            chk(bias.bias_generator_enable, |v[6:0]);
            rd(`BIAS_SELECT_ADDR, v);
        end
        // Unmapped address and masked write
        wr(12'h024, 8'hFF);
        chk(rerr, 1);
        rd(12'h024, 8'h00);
        apb(1'b1, `ROUTE_SELECT_ADDR, 32'h12, 4'h0);
        chk(rerr, 0);
        rd(`ROUTE_SELECT_ADDR, 8'hF0);
        // Reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ROUTE_SELECT_ADDR, `ROUTE_SELECT_RESET);
        rd(`BIAS_SELECT_ADDR, `BIAS_SELECT_RESET);
        rd(`MAG_CTRL_ADDR, `MAG_CTRL_RESET);
        chk(exc.low_side_switch_close, 0);
        chk(bias.bias_generator_enable, 0);
        finish_test();
    end
endmodule // excitation_bias_config_regs_tb_top
`default_nettype wire
